/* File: rtl/psp_regs.svh */
// Register map, field positions, reset values and phase timing for the
// parallel slave port. Assumes byte addresses are four times the index.
//
// Summary of operation
// - Mode bit turns data pins into slave bus
// - Mode reassigns control pins as strobes
// - Separate output and input latches, one address
// - Data direction register ignored in mode
// - Write begins when select and write low
// - Write release sets full and irq flags
// - Full flag cleared by data read or mode off
// - Second unread write sets overflow flag
// - Read start clears output full flag
// - Read release sets irq flag on Q4
// - Output full stays low until firmware write
// - Mode off holds both full flags clear
// - Leaving mode keeps overflow flag set
// - Irq flag sticky; request needs enable bit
// - Select and read low drive output latch
// - Selected write captures data pins
// - Output full shows unread firmware word
`ifndef PSP_REGS_SVH
`define PSP_REGS_SVH

// ==========================================================================
// Register indices (byte address is index times four)
`define IDX_DATA_LATCH    10'h008
`define IDX_CTL_PORT      10'h009
`define IDX_IRQ_FLAGS     10'h00C
`define IDX_DATA_DIR      10'h088
`define IDX_STATUS_CTRL   10'h089
`define IDX_IRQ_ENABLE    10'h08C
`define IDX_ANALOG_CFG    10'h09F

// ==========================================================================
// Field positions
`define BIT_IN_FULL       7
`define BIT_OUT_FULL      6
`define BIT_IN_OVF        5
`define BIT_MODE          4
`define BIT_PORT_IRQ      7

// ==========================================================================
// Reset values
`define RST_CTL_DIR       3'h7
`define RST_DATA_DIR      8'hFF

// ==========================================================================
// Bus widths and answers
`define AXI_ADDR_W        12
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

// ==========================================================================
// Internal phase clock: one count per clk, Q1..Q4 as 0..3
`define PHASE_Q2          2'h1
`define PHASE_Q4          2'h3

`endif

/* File: rtl/psp_pkg.sv */
// Types shared by the parallel slave port design.
// Assumes psp_regs.svh for all numeric constants.
`default_nettype none
package psp_pkg;

  typedef enum logic [1:0] {
    DONE_IDLE    = 2'b00,
    DONE_WAIT_Q2 = 2'b01,
    DONE_WAIT_Q4 = 2'b10
  } done_t;

  typedef struct packed {
    logic [1:0]  phase;
    done_t       done_st;
    logic        done_is_wr;
    logic        wr_act;
    logic        rd_act;
    logic [7:0]  out_latch;
    logic [7:0]  in_latch;
    logic [7:0]  data_dir;
    logic [2:0]  ctl_out;
    logic [2:0]  ctl_dir;
    logic [3:0]  a2d_cfg;
    logic        mode;
    logic        input_buffer_full;
    logic        output_buffer_full;
    logic        input_overflow_flag;
    logic        irq_flag;
    logic        irq_en;
    logic        irq_req;
    logic [7:0]  dout;
    logic [7:0]  doe_n;
    logic [2:0]  cout;
    logic [2:0]  coe_n;
    logic        aw_have;
    logic [11:0] aw_addr;
    logic        w_have;
    logic [7:0]  w_data;
    logic        w_en;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [7:0]  rdata;
  } state_t;

endpackage

`default_nettype wire

/* File: rtl/pin_sync.sv */
// Two-stage synchroniser for a group of asynchronous pin levels.
// Assumes inputs are levels that stay stable for several clocks.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int W = 11
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_st_t;

  sync_st_t st_q;
  sync_st_t st_d;

  // ========================================================================
  // First stage feeds only the second stage
  always_comb
  begin
    st_d.meta   = async_in;
    st_d.stable = st_q.meta;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign sync_out = st_q.stable;

endmodule // pin_sync

`default_nettype wire

/* File: rtl/parallel_slave_port.sv */
// Parallel slave port with AXI4-Lite register access.
// Assumes pins are asynchronous; the bench resolves wire levels from the
// active-low output enables.
`timescale 1ns/1ps
`default_nettype none
`include "psp_regs.svh"

module parallel_slave_port (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic [`AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output var  logic                   s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output var  logic                   s_axi_wready,
  output var  logic [1:0]             s_axi_bresp,
  output var  logic                   s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output var  logic                   s_axi_arready,
  output var  logic [31:0]            s_axi_rdata,
  output var  logic [1:0]             s_axi_rresp,
  output var  logic                   s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic [7:0]             data_pin_in,
  output var  logic [7:0]             data_pin_out,
  output var  logic [7:0]             data_pin_oe_n,
  input  wire logic [2:0]             ctl_pin_in,
  output var  logic [2:0]             ctl_pin_out,
  output var  logic [2:0]             ctl_pin_oe_n,
  output var  logic                   port_irq_req
);

  localparam psp_pkg::state_t ST_RESET = '{
    done_st  : psp_pkg::DONE_IDLE,
    data_dir : `RST_DATA_DIR,
    ctl_dir  : `RST_CTL_DIR,
    doe_n    : 8'hFF,
    coe_n    : 3'h7,
    awready  : 1'b1,
    wready   : 1'b1,
    arready  : 1'b1,
    default  : '0
  };

  psp_pkg::state_t st_q;
  psp_pkg::state_t st_d;

  logic [10:0] pins_s;
  logic [7:0]  data_s;
  logic [2:0]  ctl_s;
  logic        read_strobe_n;
  logic        write_strobe_n;
  logic        chip_select_n;
  logic        wr_now;
  logic        rd_now;
  logic        fire_wr;
  logic        fire_rd;
  logic        fw_data_wr;
  logic        fw_data_rd;
  logic        fw_pir_wr;
  logic        fw_ctrl_wr;
  logic [9:0]  wr_idx;
  logic [9:0]  rd_idx;
  logic [7:0]  wd;

  // ========================================================================
  // Pin synchronisers
  pin_sync #(
    .W (11)
  ) u_pin_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in ({ctl_pin_in, data_pin_in}),
    .sync_out (pins_s)
  );

  assign data_s         = pins_s[7:0];
  assign ctl_s          = pins_s[10:8];
  assign read_strobe_n  = ctl_s[0];
  assign write_strobe_n = ctl_s[1];
  assign chip_select_n  = ctl_s[2];

  // ========================================================================
  // Next-state logic
  always_comb
  begin
    st_d       = st_q;
    fire_wr    = 1'b0;
    fire_rd    = 1'b0;
    fw_data_wr = 1'b0;
    fw_data_rd = 1'b0;
    fw_pir_wr  = 1'b0;
    fw_ctrl_wr = 1'b0;
    wr_idx     = st_q.aw_addr[11:2];
    rd_idx     = s_axi_araddr[11:2];
    wd         = st_q.w_data;

    st_d.phase = st_q.phase + 2'h1;

    // Strobe decode, level sensed
    wr_now = st_q.mode & ~chip_select_n & ~write_strobe_n;
    rd_now = st_q.mode & ~chip_select_n & ~read_strobe_n;
    st_d.wr_act = wr_now;
    st_d.rd_act = rd_now;
    if (wr_now)
    begin
      st_d.in_latch = data_s;
    end

    // Completion waits for the next Q2 then fires on the Q4 after it
    unique case (st_q.done_st)
      psp_pkg::DONE_IDLE:
      begin
        if (st_q.wr_act && !wr_now)
        begin
          st_d.done_st    = psp_pkg::DONE_WAIT_Q2;
          st_d.done_is_wr = 1'b1;
        end
        else if (st_q.rd_act && !rd_now)
        begin
          st_d.done_st    = psp_pkg::DONE_WAIT_Q2;
          st_d.done_is_wr = 1'b0;
        end
      end
      psp_pkg::DONE_WAIT_Q2:
      begin
        if (st_q.phase == `PHASE_Q2)
          st_d.done_st = psp_pkg::DONE_WAIT_Q4;
      end
      psp_pkg::DONE_WAIT_Q4:
      begin
        if (st_q.phase == `PHASE_Q4)
        begin
          st_d.done_st = psp_pkg::DONE_IDLE;
          fire_wr      = st_q.done_is_wr;
          fire_rd      = ~st_q.done_is_wr;
        end
      end
      default:
        st_d.done_st = psp_pkg::DONE_IDLE;
    endcase

    // Write channel: address and data taken in either order
    if (s_axi_awvalid && st_q.awready)
    begin
      st_d.aw_have = 1'b1;
      st_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_q.wready)
    begin
      st_d.w_have = 1'b1;
      st_d.w_data = s_axi_wdata[7:0];
      st_d.w_en   = s_axi_wstrb[0];
    end
    if (st_q.bvalid && s_axi_bready)
      st_d.bvalid = 1'b0;

    if (st_q.aw_have && st_q.w_have && !st_q.bvalid)
    begin
      st_d.aw_have = 1'b0;
      st_d.w_have  = 1'b0;
      st_d.bvalid  = 1'b1;
      st_d.bresp   = `RESP_OKAY;
      unique case (wr_idx)
        `IDX_DATA_LATCH:
        begin
          if (st_q.w_en)
          begin
            st_d.out_latch = wd;
            fw_data_wr     = 1'b1;
          end
        end
        `IDX_CTL_PORT:
          if (st_q.w_en)
            st_d.ctl_out = wd[2:0];
        `IDX_IRQ_FLAGS:
        begin
          if (st_q.w_en)
          begin
            st_d.irq_flag = wd[`BIT_PORT_IRQ];
            fw_pir_wr     = 1'b1;
          end
        end
        `IDX_DATA_DIR:
          if (st_q.w_en)
            st_d.data_dir = wd;
        `IDX_STATUS_CTRL:
        begin
          if (st_q.w_en)
          begin
            st_d.input_overflow_flag = wd[`BIT_IN_OVF];
            st_d.mode    = wd[`BIT_MODE];
            st_d.ctl_dir = wd[2:0];
            fw_ctrl_wr   = 1'b1;
          end
        end
        `IDX_IRQ_ENABLE:
          if (st_q.w_en)
            st_d.irq_en = wd[`BIT_PORT_IRQ];
        `IDX_ANALOG_CFG:
          if (st_q.w_en)
            st_d.a2d_cfg = wd[3:0];
        default:
          st_d.bresp = `RESP_SLVERR;
      endcase
    end

    // Read channel
    if (s_axi_arvalid && st_q.arready)
    begin
      st_d.rvalid = 1'b1;
      st_d.rresp  = `RESP_OKAY;
      st_d.rdata  = 8'h00;
      unique case (rd_idx)
        `IDX_DATA_LATCH:
        begin
          st_d.rdata = st_q.mode ? st_q.in_latch : data_s;
          fw_data_rd = 1'b1;
        end
        `IDX_CTL_PORT:
          st_d.rdata = {5'h00, ctl_s};
        `IDX_IRQ_FLAGS:
          st_d.rdata = {st_q.irq_flag, 7'h00};
        `IDX_DATA_DIR:
          st_d.rdata = st_q.data_dir;
        `IDX_STATUS_CTRL:
          st_d.rdata = {st_q.input_buffer_full,
                        st_q.output_buffer_full,
                        st_q.input_overflow_flag, st_q.mode,
                        1'b0, st_q.ctl_dir};
        `IDX_IRQ_ENABLE:
          st_d.rdata = {st_q.irq_en, 7'h00};
        `IDX_ANALOG_CFG:
          st_d.rdata = {4'h0, st_q.a2d_cfg};
        default:
          st_d.rresp = `RESP_SLVERR;
      endcase
    end
    else if (st_q.rvalid && s_axi_rready)
    begin
      st_d.rvalid = 1'b0;
    end

    // Flag updates: clears first, then sets so a set wins; mode off clears both full flags last
    if (fw_data_rd)
      st_d.input_buffer_full = 1'b0;
    if (rd_now && !st_q.rd_act)
      st_d.output_buffer_full = 1'b0;
    if (fw_data_wr)
      st_d.output_buffer_full = 1'b1;
    if (fire_wr)
    begin
      if (st_q.input_buffer_full && !fw_data_rd)
        st_d.input_overflow_flag = 1'b1;
      st_d.input_buffer_full = 1'b1;
      st_d.irq_flag          = 1'b1;
    end
    if (fire_rd)
      st_d.irq_flag = 1'b1;
    if (!st_d.mode)
    begin
      st_d.input_buffer_full  = 1'b0;
      st_d.output_buffer_full = 1'b0;
    end

    // Handshake readiness
    st_d.awready = ~st_d.aw_have & ~st_d.bvalid;
    st_d.wready  = ~st_d.w_have & ~st_d.bvalid;
    st_d.arready = ~st_d.rvalid;

    // Pin drive: strobes own the data bus in slave mode
    st_d.dout    = st_d.out_latch;
    st_d.doe_n   = st_d.mode ? (st_d.rd_act ? 8'h00 : 8'hFF)
                             : st_d.data_dir;
    st_d.cout    = st_d.ctl_out;
    st_d.coe_n   = st_d.mode ? 3'h7 : st_d.ctl_dir;
    st_d.irq_req = st_d.irq_flag & st_d.irq_en;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      st_q <= ST_RESET;
    else
      st_q <= st_d;
  end

  // ========================================================================
  // Outputs
  assign s_axi_awready = st_q.awready;
  assign s_axi_wready  = st_q.wready;
  assign s_axi_bresp   = st_q.bresp;
  assign s_axi_bvalid  = st_q.bvalid;
  assign s_axi_arready = st_q.arready;
  assign s_axi_rdata   = {24'h000000, st_q.rdata};
  assign s_axi_rresp   = st_q.rresp;
  assign s_axi_rvalid  = st_q.rvalid;
  assign data_pin_out  = st_q.dout;
  assign data_pin_oe_n = st_q.doe_n;
  assign ctl_pin_out   = st_q.cout;
  assign ctl_pin_oe_n  = st_q.coe_n;
  assign port_irq_req  = st_q.irq_req;

  // ========================================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_rd_release;
    st_q.mode && $fell(st_q.rd_act);
  endsequence

  sequence s_flag_seen;
    ##[1:8] st_q.irq_flag;
  endsequence

  chk_read_start_clear: assert property (
    $rose(st_q.rd_act) && st_q.mode && !$past(fw_data_wr) |->
      !st_q.output_buffer_full)
    else $error("output full not cleared at read start");

  chk_flags_mode_off: assert property (
    !st_q.mode |-> !st_q.input_buffer_full && !st_q.output_buffer_full)
    else $error("full flags set while slave mode off");

  chk_flag_on_q4: assert property (
    $rose(st_q.irq_flag) && !$past(fw_pir_wr) |->
      $past(st_q.phase) == `PHASE_Q4)
    else $error("port irq flag set outside Q4");

  chk_full_with_irq: assert property (
    $rose(st_q.input_buffer_full) |-> st_q.irq_flag)
    else $error("input full set without irq flag");

  chk_full_clear_cause: assert property (
    $fell(st_q.input_buffer_full) && st_q.mode |-> $past(fw_data_rd))
    else $error("input full cleared without data read");

  chk_ovf_sticky: assert property (
    st_q.input_overflow_flag && !fw_ctrl_wr |=> st_q.input_overflow_flag)
    else $error("overflow flag dropped without firmware");

  chk_ovf_set: assert property (
    fire_wr && st_q.input_buffer_full && !fw_data_rd |=>
      st_q.input_overflow_flag)
    else $error("overflow not flagged on unread write");

  chk_rd_complete: assert property (
    s_rd_release |-> s_flag_seen)
    else $error("read completion flag missing");

  chk_drive_on_read: assert property (
    st_q.mode && st_q.rd_act |->
      st_q.doe_n == 8'h00 && st_q.dout == st_q.out_latch)
    else $error("data pins not driven during read");

  chk_irq_request: assert property (
    $rose(st_q.irq_flag) && st_q.irq_en && !fw_pir_wr |-> port_irq_req)
    else $error("irq request not raised with enable");

endmodule // parallel_slave_port

`default_nettype wire

/* File: verif/ext_host_model.sv */
// External 8-bit host that drives the slave port strobes and data.
// Assumes the bench resolves the shared data and control wires.
`timescale 1ns/1ps
`default_nettype none

module ext_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] bus_in,
  output var  logic       cs_n,
  output var  logic       wr_n,
  output var  logic       rd_n,
  output var  logic [7:0] bus_out
);
  initial
  begin
    cs_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    bus_out = 8'h00;
  end

  // ========
  // Bus cycles; a released bus shows the inverse of the last byte
  task automatic host_wr(input logic [7:0] d, input int hold);
    @(posedge clk);
    cs_n    <= 1'b0;
    wr_n    <= 1'b0;
    bus_out <= d;
    repeat (hold) @(posedge clk);
    cs_n <= 1'b1;
    wr_n <= 1'b1;
    @(posedge clk);
    bus_out <= ~d;
    repeat (12) @(posedge clk);
  endtask

  task automatic host_rd(output logic [7:0] d, input int hold);
    @(posedge clk);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    repeat (hold) @(posedge clk);
    d = bus_in;
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    repeat (12) @(posedge clk);
  endtask
endmodule // ext_host_model
`default_nettype wire

/* File: verif/parallel_slave_port_tb_top.sv */
// Self-checking bench for the parallel slave port.
// Assumes the design and the host model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "psp_regs.svh"

module parallel_slave_port_tb_top;
  typedef struct packed {
    logic [9:0] idx;
    logic [7:0] d;
    logic [3:0] strb;
    logic [1:0] resp;
    logic [7:0] exp;
  } row_t;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq_req;
  logic        cs_n, wr_n, rd_n;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [7:0]  dout, doe_n, host_out, data_wire, rd_val;
  logic [2:0]  cout, coe_n, ctl_wire;
  int          mismatches = 0;
  int          comparisons = 0;

  row_t rst_rows [5] = '{
    '{`IDX_STATUS_CTRL, 8'h00, 4'h0, `RESP_OKAY, 8'h07},
    '{`IDX_IRQ_FLAGS,   8'h00, 4'h0, `RESP_OKAY, 8'h00},
    '{`IDX_IRQ_ENABLE,  8'h00, 4'h0, `RESP_OKAY, 8'h00},
    '{`IDX_ANALOG_CFG,  8'h00, 4'h0, `RESP_OKAY, 8'h00},
    '{`IDX_DATA_DIR,    8'h00, 4'h0, `RESP_OKAY, 8'hFF}};

  row_t rows [7] = '{
    '{`IDX_IRQ_ENABLE,  8'h80, 4'hF, `RESP_OKAY,   8'h80},
    '{`IDX_ANALOG_CFG,  8'h06, 4'hF, `RESP_OKAY,   8'h06},
    '{`IDX_DATA_DIR,    8'h0F, 4'hF, `RESP_OKAY,   8'h0F},
    '{`IDX_ANALOG_CFG,  8'h09, 4'hE, `RESP_OKAY,   8'h06},
    '{10'h050,          8'h5A, 4'hF, `RESP_SLVERR, 8'h00},
    '{`IDX_STATUS_CTRL, 8'hDF, 4'hF, `RESP_OKAY,   8'h17},
    '{`IDX_STATUS_CTRL, 8'h17, 4'hF, `RESP_OKAY,   8'h17}};

  assign data_wire = (~doe_n & dout) | (doe_n & host_out);
  assign ctl_wire  = (~coe_n & cout) | (coe_n & {cs_n, wr_n, rd_n});

  always #5 clk = ~clk;

  parallel_slave_port uut (
    .clk(clk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .data_pin_in(data_wire), .data_pin_out(dout), .data_pin_oe_n(doe_n),
    .ctl_pin_in(ctl_wire), .ctl_pin_out(cout), .ctl_pin_oe_n(coe_n),
    .port_irq_req(irq_req)
  );

  ext_host_model host (
    .clk(clk), .bus_in(data_wire), .cs_n(cs_n), .wr_n(wr_n),
    .rd_n(rd_n), .bus_out(host_out)
  );

  // ========
  // Checking and bus tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic axi_wr(input logic [9:0] idx, input logic [7:0] d,
                        input logic [3:0] strb, input logic [1:0] resp);
    int         n;
    logic       aw_hs;
    logic       w_hs;
    logic       b_hs;
    logic [1:0] b_got;
    n     = 0;
    b_hs  = 1'b0;
    b_got = 2'h0;
    @(posedge clk);
    awaddr  <= {idx, 2'b00};
    wdata   <= {24'h000000, d};
    wstrb   <= strb;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    // Handshakes are judged on settled levels before the taking edge
    do
    begin
      @(negedge clk);
      aw_hs = awvalid && (awready === 1'b1);
      w_hs  = wvalid && (wready === 1'b1);
      b_hs  = (bvalid === 1'b1);
      b_got = bresp;
      @(posedge clk);
      n++;
      if (aw_hs)
        awvalid <= 1'b0;
      if (w_hs)
        wvalid <= 1'b0;
    end while (!b_hs && n < 100);
    check({31'h0, b_hs}, 32'h1);
    check({30'h0, b_got}, {30'h0, resp});
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [9:0] idx, input logic [7:0] exp,
                        input logic [1:0] resp);
    int          n;
    logic        ar_hs;
    logic        r_hs;
    logic [31:0] r_got;
    logic [1:0]  r_resp;
    n      = 0;
    r_hs   = 1'b0;
    r_got  = 32'h0;
    r_resp = 2'h0;
    @(posedge clk);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(negedge clk);
      ar_hs  = arvalid && (arready === 1'b1);
      r_hs   = (rvalid === 1'b1);
      r_got  = rdata;
      r_resp = rresp;
      @(posedge clk);
      n++;
      if (ar_hs)
        arvalid <= 1'b0;
    end while (!r_hs && n < 100);
    check({31'h0, r_hs}, 32'h1);
    check(r_got, {24'h000000, exp});
    check({30'h0, r_resp}, {30'h0, resp});
    rready <= 1'b0;
  endtask

  task automatic give_verdict();
    if (mismatches == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ========
  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    check({24'h000000, doe_n}, 32'hFF);
    check({31'h0, irq_req}, 32'h0);
    foreach (rst_rows[i])
      axi_rd(rst_rows[i].idx, rst_rows[i].exp, rst_rows[i].resp);
    foreach (rows[i])
    begin
      axi_wr(rows[i].idx, rows[i].d, rows[i].strb, rows[i].resp);
      axi_rd(rows[i].idx, rows[i].exp, rows[i].resp);
    end
    host.host_wr(8'hA5, 3);
    axi_rd(`IDX_STATUS_CTRL, 8'h97, `RESP_OKAY);
    axi_rd(`IDX_IRQ_FLAGS, 8'h80, `RESP_OKAY);
    check({31'h0, irq_req}, 32'h1);
    host.host_wr(8'h5A, 6);
    axi_rd(`IDX_STATUS_CTRL, 8'hB7, `RESP_OKAY);
    axi_rd(`IDX_DATA_LATCH, 8'h5A, `RESP_OKAY);
    axi_rd(`IDX_STATUS_CTRL, 8'h37, `RESP_OKAY);
    axi_wr(`IDX_IRQ_FLAGS, 8'h00, 4'hF, `RESP_OKAY);
    check({31'h0, irq_req}, 32'h0);
    axi_wr(`IDX_IRQ_ENABLE, 8'h00, 4'hF, `RESP_OKAY);
    axi_wr(`IDX_DATA_LATCH, 8'h3C, 4'hF, `RESP_OKAY);
    axi_rd(`IDX_STATUS_CTRL, 8'h77, `RESP_OKAY);
    check({24'h000000, doe_n}, 32'hFF);
    host.host_rd(rd_val, 5);
    check({24'h000000, rd_val}, 32'h3C);
    axi_rd(`IDX_STATUS_CTRL, 8'h37, `RESP_OKAY);
    axi_rd(`IDX_IRQ_FLAGS, 8'h80, `RESP_OKAY);
    check({31'h0, irq_req}, 32'h0);
    axi_wr(`IDX_DATA_LATCH, 8'h11, 4'hF, `RESP_OKAY);
    host.host_wr(8'h22, 3);
    axi_rd(`IDX_STATUS_CTRL, 8'hF7, `RESP_OKAY);
    axi_wr(`IDX_STATUS_CTRL, 8'h27, 4'hF, `RESP_OKAY);
    axi_rd(`IDX_STATUS_CTRL, 8'h27, `RESP_OKAY);
    check({24'h000000, doe_n}, 32'h0F);
    host.host_wr(8'h33, 3);
    axi_rd(`IDX_STATUS_CTRL, 8'h27, `RESP_OKAY);
    axi_wr(`IDX_STATUS_CTRL, 8'h20, 4'hF, `RESP_OKAY);
    axi_wr(`IDX_CTL_PORT, 8'h05, 4'hF, `RESP_OKAY);
    check({29'h0, coe_n}, 32'h0);
    check({29'h0, cout}, 32'h5);
    axi_rd(`IDX_CTL_PORT, 8'h05, `RESP_OKAY);
    give_verdict();
  end

  // Watchdog cuts a hang short
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    give_verdict();
  end
endmodule // parallel_slave_port_tb_top
`default_nettype wire
